// *** rtl/ptpskw_pkg.sv ***
// constants shared by the timestamp and lane skew report block
`default_nettype none
package ptpskw_pkg;
   // ==========================================================
   // widths
   localparam int TS_W = 80;        // timer and stamp, lsb is 1 ns
   localparam int TAG_W = 16;       // client tag of a timing frame
   localparam int DATA_W = 64;      // stream beat width
   localparam int LANES = 4;        // lanes at 40G, 2 used at 50G
   localparam int LANES_50G = 2;    // lanes used at 50G
   localparam int LANE_W = 2;       // lane index width
   localparam int LEVEL_W = 6;      // aligner fill level, SerDes cycles
   localparam int LEVELS_W = LANES * LEVEL_W;
   // fifo word: last, sop, data, stamp, lane, levels
   localparam int WORD_W = 2 + DATA_W + TS_W + LANE_W + LEVELS_W;
   localparam int FIFO_DEPTH = 4;   // words in the receive fifo
   localparam int FIFO_AW = 2;      // fifo pointer width
   localparam int FIFO_CW = 3;      // fifo occupancy width
   localparam int SOP_CW = 4;       // frame counter width for checks
   localparam int MAX_INFLIGHT = 5; // fifo words plus output stage
   // ==========================================================
   // field positions inside a fifo word
   localparam int F_LEVELS = 0;
   localparam int F_LANE = F_LEVELS + LEVELS_W;
   localparam int F_STAMP = F_LANE + LANE_W;
   localparam int F_DATA = F_STAMP + TS_W;
   localparam int F_SOP = F_DATA + DATA_W;
   localparam int F_LAST = F_SOP + 1;
   // ==========================================================
   // values after reset
   localparam logic [TS_W-1:0] RST_STAMP = 80'h0;
   localparam logic [TAG_W-1:0] RST_TAG = 16'h0;
   localparam logic [DATA_W-1:0] RST_DATA = 64'h0;
   localparam logic [LANE_W-1:0] RST_LANE = 2'h0;
   localparam logic [LEVELS_W-1:0] RST_LEVELS = 24'h0;
endpackage : ptpskw_pkg
`default_nettype wire

// *** rtl/ptpskw_fifo.sv ***
// small valid/ready fifo with registered input ready
`default_nettype none
module ptpskw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4,
   parameter int AW = 2,
   parameter int CW = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // ==========================================================
   // storage and pointers
   logic [WIDTH-1:0] mem [DEPTH];     // word store
   logic [AW-1:0] wr_ptr_reg;         // next slot to write
   logic [AW-1:0] rd_ptr_reg;         // oldest word
   logic [CW-1:0] count_reg;          // words held
   logic [CW-1:0] count_next;
   logic ready_reg;                   // not full, registered
   wire push = in_valid && ready_reg;
   wire pop = out_valid && out_ready;
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   // honest empty and full from the occupancy count
   assign out_valid = (count_reg != '0);
   assign in_ready = ready_reg;
   assign out_data = mem[rd_ptr_reg];
   assign count_next = count_reg + CW'(push) - CW'(pop);

   // ==========================================================
   // word store, written only on an accepted push
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers, count and ready
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count_reg <= count_next;
         ready_reg <= (count_next != FULL_COUNT);
      end
   end
endmodule // ptpskw_fifo
`default_nettype wire

// *** rtl/ptpskw_top.sv ***
// frame timestamp capture and receive lane skew report
// Behaviour
// - 80-bit stamp valid on first packet beat
// - every received frame is stamped
// - transmit stamp only for tagged timing frames
// - stamp sampled as start crosses capture plane
// - stamp presented with the start beat
// - stamp lsb is one nanosecond
// - error correction sits line side of capture
// - report start lane and per-lane fill levels
// - tag in with frame, returned with stamp
`default_nettype none
module ptpskw_top (
   // clock, reset and lane mode
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic MODE_50G,
   input wire logic [ptpskw_pkg::TS_W-1:0] RX_TIMER,
   // receive stream from the lane aligner
   input wire logic RX_IN_VALID,
   output logic RX_IN_READY,
   input wire logic RX_IN_SOP,
   input wire logic RX_IN_LAST,
   input wire logic [ptpskw_pkg::DATA_W-1:0] RX_IN_DATA,
   input wire logic [ptpskw_pkg::LANE_W-1:0] RX_IN_SOP_LANE,
   input wire logic [ptpskw_pkg::LEVELS_W-1:0] RX_IN_LEVELS,
   // user side stream with stamp and skew report
   output logic RX_TVALID,
   input wire logic RX_TREADY,
   output logic RX_TLAST,
   output logic RX_TSOP,
   output logic [ptpskw_pkg::DATA_W-1:0] RX_TDATA,
   output logic [ptpskw_pkg::TS_W-1:0] RX_TSTAMP,
   output logic [ptpskw_pkg::LANE_W-1:0] RX_SOP_LANE_INDEX,
   output logic [ptpskw_pkg::LEVELS_W-1:0] RX_LANE_ALIGN_BUFFER_LEVEL,
   // transmit capture
   input wire logic [ptpskw_pkg::TS_W-1:0] TX_TIMER,
   input wire logic TX_SOP,
   input wire logic TX_TIMING_FRAME,
   input wire logic [ptpskw_pkg::TAG_W-1:0] TX_TAG,
   output logic TX_TSTAMP_VALID,
   output logic [ptpskw_pkg::TS_W-1:0] TX_TSTAMP,
   output logic [ptpskw_pkg::TAG_W-1:0] TX_TSTAMP_TAG
);
   // ==========================================================
   // helpers
   // clear the fill levels of lanes unused in the current mode
   function automatic logic [ptpskw_pkg::LEVELS_W-1:0] mask_levels(
      input logic [ptpskw_pkg::LEVELS_W-1:0] lv, input logic m50);
      logic [ptpskw_pkg::LEVELS_W-1:0] r;
      r = lv;
      if (m50) begin
         r[ptpskw_pkg::LEVELS_W-1:ptpskw_pkg::LANES_50G*ptpskw_pkg::LEVEL_W]
            = '0;
      end
      return r;
   endfunction

   // ==========================================================
   // receive capture plane
   // the incoming stream is already decoded, so any error correction
   // stays on the line side and never moves this point
   logic fifo_in_ready;               // room in the fifo
   logic fifo_out_valid;              // a word is waiting
   logic fifo_out_ready;              // output stage takes it
   logic [ptpskw_pkg::WORD_W-1:0] fifo_out_word;
   logic [ptpskw_pkg::WORD_W-1:0] cap_word; // beat plus its stamp
   wire in_fire = RX_IN_VALID && fifo_in_ready;
   wire [ptpskw_pkg::LANE_W-1:0] lane_idx = MODE_50G ?
      {1'b0, RX_IN_SOP_LANE[0]} : RX_IN_SOP_LANE;
   // the timer is sampled in the very cycle the start is taken
   wire [ptpskw_pkg::TS_W-1:0] cap_stamp =
      RX_IN_SOP ? RX_TIMER : ptpskw_pkg::RST_STAMP;
   wire [ptpskw_pkg::LEVELS_W-1:0] cap_levels = RX_IN_SOP ?
      mask_levels(RX_IN_LEVELS, MODE_50G) : ptpskw_pkg::RST_LEVELS;

   // every start is stamped, with no look at the frame type
   assign cap_word = {RX_IN_LAST, RX_IN_SOP, RX_IN_DATA, cap_stamp,
      RX_IN_SOP ? lane_idx : ptpskw_pkg::RST_LANE, cap_levels};

   // stamp rides in the same word as its beat, so it cannot slip
   ptpskw_fifo #(
      .WIDTH(ptpskw_pkg::WORD_W),
      .DEPTH(ptpskw_pkg::FIFO_DEPTH),
      .AW(ptpskw_pkg::FIFO_AW),
      .CW(ptpskw_pkg::FIFO_CW)
   ) u_fifo (
      .clk(REF_CLK),
      .rst(RST),
      .in_valid(RX_IN_VALID),
      .in_ready(fifo_in_ready),
      .in_data(cap_word),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_word)
   );

   // ready comes straight from the fifo's own register
   assign RX_IN_READY = fifo_in_ready;

   // ==========================================================
   // user side output stage
   // the stage reloads when empty or when the client takes the beat
   logic out_valid_reg;
   assign fifo_out_ready = !out_valid_reg || RX_TREADY;
   wire load = fifo_out_valid && fifo_out_ready;

   // valid flag of the output beat
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         out_valid_reg <= 1'b0;
      end else if (fifo_out_ready) begin
         out_valid_reg <= fifo_out_valid;
      end
   end

   // beat, stamp and skew report leave together
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         RX_TLAST <= 1'b0;
         RX_TSOP <= 1'b0;
         RX_TDATA <= ptpskw_pkg::RST_DATA;
         RX_TSTAMP <= ptpskw_pkg::RST_STAMP;
         RX_SOP_LANE_INDEX <= ptpskw_pkg::RST_LANE;
         RX_LANE_ALIGN_BUFFER_LEVEL <= ptpskw_pkg::RST_LEVELS;
      end else if (load) begin
         RX_TLAST <= fifo_out_word[ptpskw_pkg::F_LAST];
         RX_TSOP <= fifo_out_word[ptpskw_pkg::F_SOP];
         RX_TDATA <= fifo_out_word[ptpskw_pkg::F_DATA +: ptpskw_pkg::DATA_W];
         RX_TSTAMP <= fifo_out_word[ptpskw_pkg::F_STAMP +:
            ptpskw_pkg::TS_W];
         RX_SOP_LANE_INDEX <= fifo_out_word[ptpskw_pkg::F_LANE +:
            ptpskw_pkg::LANE_W];
         RX_LANE_ALIGN_BUFFER_LEVEL <= fifo_out_word[ptpskw_pkg::F_LEVELS +:
            ptpskw_pkg::LEVELS_W];
      end
   end

   // valid comes straight from the output stage flag
   assign RX_TVALID = out_valid_reg;

   // ==========================================================
   // transmit capture
   // only starts the client tagged as timing frames are stamped
   wire tx_take = TX_SOP && TX_TIMING_FRAME;

   // one-cycle report of stamp and tag, both held afterwards
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         TX_TSTAMP_VALID <= 1'b0;
         TX_TSTAMP <= ptpskw_pkg::RST_STAMP;
         TX_TSTAMP_TAG <= ptpskw_pkg::RST_TAG;
      end else begin
         TX_TSTAMP_VALID <= tx_take;
         if (tx_take) begin
            TX_TSTAMP <= TX_TIMER;
            TX_TSTAMP_TAG <= TX_TAG;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   // frames taken in and frames handed out, for pairing checks
   logic [ptpskw_pkg::SOP_CW-1:0] sop_in_cnt_reg;
   logic [ptpskw_pkg::SOP_CW-1:0] sop_out_cnt_reg;
   wire [ptpskw_pkg::SOP_CW-1:0] sop_gap = sop_in_cnt_reg - sop_out_cnt_reg;
   localparam logic [ptpskw_pkg::SOP_CW-1:0] GAP_MAX =
      ptpskw_pkg::SOP_CW'(ptpskw_pkg::MAX_INFLIGHT);

   // count starts on both sides of the buffer
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         sop_in_cnt_reg <= '0;
         sop_out_cnt_reg <= '0;
      end else begin
         sop_in_cnt_reg <= sop_in_cnt_reg +
            ptpskw_pkg::SOP_CW'(in_fire && RX_IN_SOP);
         sop_out_cnt_reg <= sop_out_cnt_reg +
            ptpskw_pkg::SOP_CW'(RX_TVALID && RX_TREADY && RX_TSOP);
      end
   end

   // only a start beat may carry a stamp
   property p_rx_stamp_only_sop;
      RX_TVALID && !RX_TSOP |-> RX_TSTAMP == '0;
   endproperty
   a_rx_stamp_only_sop: assert property (p_rx_stamp_only_sop)
      else $error("stamp present on a non-start beat");

   // a taken start is always counted as awaiting its stamp
   property p_rx_every_sop;
      in_fire && RX_IN_SOP |=> sop_gap != '0;
   endproperty
   a_rx_every_sop: assert property (p_rx_every_sop)
      else $error("received start was not counted for stamping");

   // no more stamped frames in flight than words of storage
   property p_rx_inflight;
      sop_gap <= GAP_MAX;
   endproperty
   a_rx_inflight: assert property (p_rx_inflight)
      else $error("more stamped frames in flight than storage");

   // a stalled beat keeps its stamp and data
   property p_rx_hold;
      RX_TVALID && !RX_TREADY |=>
         RX_TVALID && $stable(RX_TSTAMP) && $stable(RX_TSOP)
         && $stable(RX_TDATA);
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("stamp or beat changed while stalled");

   // at 50G only the two lower lanes are reported
   property p_rx_lane_50g;
      RX_TVALID && MODE_50G |->
         RX_SOP_LANE_INDEX < 2'h2 &&
         RX_LANE_ALIGN_BUFFER_LEVEL[23:12] == 12'h000;
   endproperty
   a_rx_lane_50g: assert property (p_rx_lane_50g)
      else $error("unused lane reported in 50G mode");

   // an untagged transmit start gives no report
   property p_tx_untagged;
      TX_SOP && !TX_TIMING_FRAME |=> !TX_TSTAMP_VALID;
   endproperty
   a_tx_untagged: assert property (p_tx_untagged)
      else $error("untagged transmit frame was stamped");

   // a tagged start reports the timer of its own edge
   property p_tx_stamp;
      TX_SOP && TX_TIMING_FRAME |=>
         TX_TSTAMP_VALID && TX_TSTAMP == $past(TX_TIMER);
   endproperty
   a_tx_stamp: assert property (p_tx_stamp)
      else $error("transmit stamp missing or wrong");

   // the tag returns with its stamp and is still there one cycle later unless a new report comes
   property p_tx_tag;
      TX_SOP && TX_TIMING_FRAME |=> TX_TSTAMP_TAG == $past(TX_TAG)
         ##1 TX_TSTAMP_VALID || TX_TSTAMP_TAG == $past(TX_TAG, 2);
   endproperty
   a_tx_tag: assert property (p_tx_tag)
      else $error("returned tag does not match the frame");

   // a start behind no other start reaches the client in time
   property p_rx_sop_exit;
      in_fire && RX_IN_SOP && RX_TREADY && sop_gap == '0 |->
         ##[1:8] RX_TVALID && RX_TSOP;
   endproperty
   a_rx_sop_exit: assert property (p_rx_sop_exit)
      else $error("stamped start did not reach the user side");

   // a non-start beat carries no lane and no fill levels
   property p_rx_plain_beat;
      RX_TVALID && !RX_TSOP |->
         RX_SOP_LANE_INDEX == '0 && RX_LANE_ALIGN_BUFFER_LEVEL == '0;
   endproperty
   a_rx_plain_beat: assert property (p_rx_plain_beat)
      else $error("lane or levels present on a non-start beat");

   // into an empty path the start leaves two edges after it was taken,
   // carrying the timer value of the taking edge
   property p_rx_walk;
      in_fire && RX_IN_SOP && !RX_TVALID && !fifo_out_valid |=>
         ##1 RX_TVALID && RX_TSOP && RX_TSTAMP == $past(RX_TIMER, 2);
   endproperty
   a_rx_walk: assert property (p_rx_walk)
      else $error("stamp of an idle path start is late or wrong");

   // the output stage empties when it hands over its last word
   property p_rx_drain;
      RX_TVALID && RX_TREADY && !fifo_out_valid |=> !RX_TVALID;
   endproperty
   a_rx_drain: assert property (p_rx_drain)
      else $error("beat handed over twice");

   // a transmit report follows a tagged start and nothing else
   property p_tx_only_take;
      TX_TSTAMP_VALID |-> $past(tx_take);
   endproperty
   a_tx_only_take: assert property (p_tx_only_take)
      else $error("transmit report without a tagged start");

   // between reports the stamp and its tag stand still
   property p_tx_held;
      !TX_TSTAMP_VALID |-> $stable(TX_TSTAMP) && $stable(TX_TSTAMP_TAG);
   endproperty
   a_tx_held: assert property (p_tx_held)
      else $error("transmit stamp or tag moved without a report");

   c_rx_sop: cover property (RX_TVALID && RX_TREADY && RX_TSOP);
   c_rx_stall: cover property (RX_IN_VALID && !RX_IN_READY);
   c_tx_stamp: cover property (TX_TSTAMP_VALID);
   c_rx_50g: cover property (RX_TVALID && RX_TSOP && MODE_50G);
   c_tx_back: cover property (TX_TSTAMP_VALID && tx_take);
endmodule // ptpskw_top
`default_nettype wire

// *** tb/ptpskw_sink.sv ***
// client model: stream sink with stall control and skew correction
`default_nettype none
module ptpskw_sink #(
   parameter int PERIOD_NS = 3 // serdes period in stamp units
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic stall,
   input wire logic slow,
   input wire logic tvalid,
   input wire logic tsop,
   output logic tready,
   input wire logic [ptpskw_pkg::TS_W-1:0] tstamp,
   input wire logic [ptpskw_pkg::LANE_W-1:0] lane,
   input wire logic [ptpskw_pkg::LEVELS_W-1:0] levels,
   output logic [ptpskw_pkg::TS_W-1:0] corrected,
   output logic signed [15:0] diff_sum,
   output logic [7:0] sop_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic phase_reg; // alternates for slow pacing
   logic [5:0] sof_level; // fill of the start lane
   logic [5:0] ref_level; // fill of the stamp lane
   logic signed [7:0] diff; // fill difference in serdes cycles
   // ==========================================================
   // pacing: stall holds ready low, slow accepts every other cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) phase_reg <= 1'b0;
      else phase_reg <= ~phase_reg;
   end
   assign tready = ~stall & ~(slow & phase_reg);
   // ==========================================================
   // skew correction on the beat it belongs to
   assign sof_level = levels[lane*6 +: 6];
   assign ref_level = levels[5:0];
   assign diff = $signed({2'b00, sof_level}) - $signed({2'b00, ref_level});
   assign corrected = tstamp + 80'(diff * PERIOD_NS);
   // ==========================================================
   // time average of the fill difference: a running sum and the count
   // of starts behind it, so short-term jitter can be divided out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         diff_sum <= '0;
         sop_seen <= '0;
      end else if (tvalid && tready && tsop) begin
         diff_sum <= diff_sum + 16'(diff);
         sop_seen <= sop_seen + 8'h01;
      end
   end
endmodule // ptpskw_sink
`default_nettype wire

// *** tb/ptpskw_top_tb.sv ***
// self-checking bench for the timestamp and lane skew block
`default_nettype none
module ptpskw_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SKW_PERIOD = 3; // serdes period given to the client
   typedef struct {
      logic sop; logic last; logic [63:0] data;
      logic [79:0] stamp; logic [1:0] lane; logic [23:0] lv;
   } ptpskw_beat_t;
   ptpskw_beat_t exp_q[$]; // beats expected at the client
   int failures = 0;
   int total_checks = 0;
   logic ref_clk = 0, rst = 1, mode = 0, stall = 0, slow = 0;
   logic in_valid = 0, in_ready, in_sop = 0, in_last = 0;
   logic [63:0] in_data = '0, tdata;
   logic [1:0] in_lane = '0, lane;
   logic [23:0] in_lv = '0, lv;
   logic [79:0] rx_timer = 80'h100, tx_timer, tstamp, corrected;
   logic tvalid, tready, tlast, tsop, tx_sop = 0, tx_timing = 0;
   logic [15:0] tx_tag = '0, ts_tag;
   logic ts_valid;
   logic [79:0] ts_stamp;
   logic signed [15:0] dsum; // running fill difference at the client
   logic [7:0] sop_seen; // starts the client has averaged over
   int exp_dsum = 0;
   int exp_sops = 0;
   // ==========================================================
   // clock, and timers synchronous to it in one format
   initial forever #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) rx_timer <= #1 rx_timer + 80'h7;
   assign tx_timer = rx_timer ^ 80'h5A00;
   // ==========================================================
   // instances
   ptpskw_top dut_u (.REF_CLK(ref_clk), .RST(rst), .MODE_50G(mode),
      .RX_TIMER(rx_timer), .RX_IN_VALID(in_valid), .RX_IN_READY(in_ready),
      .RX_IN_SOP(in_sop), .RX_IN_LAST(in_last), .RX_IN_DATA(in_data),
      .RX_IN_SOP_LANE(in_lane), .RX_IN_LEVELS(in_lv), .RX_TVALID(tvalid),
      .RX_TREADY(tready), .RX_TLAST(tlast), .RX_TSOP(tsop),
      .RX_TDATA(tdata), .RX_TSTAMP(tstamp), .RX_SOP_LANE_INDEX(lane),
      .RX_LANE_ALIGN_BUFFER_LEVEL(lv), .TX_TIMER(tx_timer),
      .TX_SOP(tx_sop), .TX_TIMING_FRAME(tx_timing), .TX_TAG(tx_tag),
      .TX_TSTAMP_VALID(ts_valid), .TX_TSTAMP(ts_stamp),
      .TX_TSTAMP_TAG(ts_tag));
   ptpskw_sink #(.PERIOD_NS(SKW_PERIOD)) sink_u (.clk(ref_clk),
      .rst(rst), .stall(stall), .slow(slow), .tvalid(tvalid),
      .tsop(tsop), .tready(tready), .tstamp(tstamp), .lane(lane),
      .levels(lv), .corrected(corrected), .diff_sum(dsum),
      .sop_seen(sop_seen));
   // ==========================================================
   // compare tasks and verdict
   task automatic chk_field(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_stamp(input logic [79:0] got, input logic [79:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================
   // monitor: every beat the next edge hands over, looked at in mid-cycle
   // where the design's outputs are settled
   always @(negedge ref_clk) begin : mon
      ptpskw_beat_t e;
      int c;
      if (tvalid === 1'b1 && tready === 1'b1) begin
         if (exp_q.size() == 0) chk_field(64'h1, 64'h0);
         else begin
            e = exp_q.pop_front();
            c = int'(e.lv[e.lane*6 +: 6]) - int'(e.lv[5:0]);
            chk_field(tsop, e.sop);
            chk_field({tlast, tdata}, {e.last, e.data});
            chk_stamp(tstamp, e.stamp);
            chk_field({lane, lv}, {e.lane, e.lv});
            if (e.sop) begin
               chk_stamp(corrected, e.stamp + 80'(c * SKW_PERIOD));
               exp_dsum += c;
               exp_sops++;
            end
         end
      end
   end
   // ==========================================================
   // stream driver: holds the beat until an edge with ready high, for at most 20 edges
   task automatic send(input logic sop, input logic last,
         input logic [63:0] d, input logic [1:0] ln,
         input logic [23:0] l, output bit ok);
      ptpskw_beat_t e;
      int n;
      {in_valid, in_sop, in_last, in_data, in_lane, in_lv} =
         {1'b1, sop, last, d, ln, l};
      ok = 0;
      n = 0;
      while (!ok && n < 20) begin
         @(negedge ref_clk);
         ok = (in_ready === 1'b1);
         e.stamp = sop ? rx_timer : '0;
         @(posedge ref_clk);
         #1;
         n++;
      end
      e.sop = sop;
      e.last = last;
      e.data = d;
      e.lane = sop ? (ln & {~mode, 1'b1}) : '0;
      e.lv = sop ? (mode ? {12'h0, l[11:0]} : l) : '0;
      if (ok) exp_q.push_back(e);
   endtask
   task automatic drain(input string name);
      int n;
      in_valid = 0;
      for (n = 0; n < 200 && exp_q.size() != 0; n++) @(posedge ref_clk);
      #1;
      chk_field(64'(exp_q.size()), 64'h0);
      chk_field(64'(dsum), 64'(exp_dsum));
      chk_field(64'(sop_seen), 64'(exp_sops));
      $display("test %s done", name);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_frames();
      bit ok;
      int i;
      for (i = 0; i < 4; i++) begin
         slow = i[1];
         send(1, 0, 64'hA0 + i, 2'(i), 24'h28_C4_45, ok);
         send(0, i == 3, 64'hB0 + i, 2'(3 - i), 24'hFFFFFF, ok);
      end
      send(1, 1, 64'hC0, 2'h2, 24'h01_3F_00, ok);
      drain("frames");
   endtask
   task automatic t_fill();
      bit ok;
      int cnt;
      stall = 1;
      cnt = 0;
      ok = 1;
      while (ok && cnt < 8) begin
         send(cnt == 0, 0, 64'hD0 + cnt, 2'h1, 24'h0C_30_C3, ok);
         if (ok) cnt++;
      end
      chk_field(64'(cnt), 64'(ptpskw_pkg::MAX_INFLIGHT));
      stall = 0;
      drain("fill");
   endtask
   task automatic t_50g();
      bit ok;
      mode = 1;
      send(1, 1, 64'hE0, 2'h3, 24'hFF_FF_C7, ok);
      drain("50g");
      mode = 0;
   endtask
   task automatic tx_chk(input logic v, input logic [79:0] s,
         input logic [15:0] t);
      @(negedge ref_clk);
      chk_field(ts_valid, v);
      chk_stamp(ts_stamp, s);
      chk_field(ts_tag, t);
   endtask
   task automatic t_tx();
      logic [79:0] sa, sb;
      {tx_sop, tx_timing, tx_tag} = {2'b11, 16'h1234};
      @(negedge ref_clk);
      sa = tx_timer;
      @(posedge ref_clk);
      #1;
      tx_tag = 16'hBEEF;
      tx_chk(1, sa, 16'h1234);
      sb = tx_timer;
      @(posedge ref_clk);
      #1;
      tx_timing = 0;
      tx_chk(1, sb, 16'hBEEF);
      @(posedge ref_clk);
      #1;
      tx_sop = 0;
      tx_chk(0, sb, 16'hBEEF);
      $display("test tx done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (6) @(posedge ref_clk);
      #1;
      rst = 0;
      repeat (2) @(posedge ref_clk);
      #1;
      t_frames();
      t_fill();
      t_50g();
      t_tx();
      final_report();
   end
   initial begin
      #300000;
      failures++;
      final_report();
   end
endmodule // ptpskw_top_tb
`default_nettype wire
